/* rtl/tcc_pkg.sv */
// Package for the time code configuration and status block.
// Assumes a single 200 MHz clock; all timing counts derive from it.
package tcc_pkg;

  // Clock and derived timing
  localparam int CLK_HZ = 200_000_000;
  localparam int SEC_CYC = CLK_HZ;
  localparam int PPS_WIDTH_MS = 100;
  localparam int PPS_WIDTH_CYC = PPS_WIDTH_MS * (CLK_HZ / 1000);
  localparam int LED_FLASH_MS = 125;
  localparam int LED_FLASH_CYC = LED_FLASH_MS * (CLK_HZ / 1000);
  localparam int LED_HALF_MS = 500;
  localparam int LED_HALF_CYC = LED_HALF_MS * (CLK_HZ / 1000);
  localparam int BAUD_RATE = 9600;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam int UART_BITS = 10;
  localparam int FIX_LOSS_SEC = 600;

  // Switch bank field positions (bit 0 is switch position one)
  localparam int SW_WIDTH = 12;
  localparam int SW_MAG_LSB = 0;
  localparam int SW_NEG = 4;
  localparam int SW_HALF = 5;
  localparam int SW_DST = 6;
  localparam int SW_FMT_LSB = 8;
  localparam int SW_SERIAL = 11;
  localparam logic [3:0] MAG_MAX = 4'hC;

  // Minute arithmetic
  localparam logic [12:0] MIN_PER_HOUR = 13'h003C;
  localparam logic [12:0] MIN_HALF_HOUR = 13'h001E;
  localparam logic [12:0] MIN_PER_DAY = 13'h05A0;
  localparam logic [8:0] DAYS_PER_YEAR = 9'h16D;

  // Broadcast string
  localparam int STR_LEN = 16;
  localparam int CR_IDX = 14;
  localparam logic [7:0] CH_SOH = 8'h01;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_LOCKED = 8'h20;
  localparam logic [7:0] CH_UNLOCKED = 8'h3F;

  // DST window months and change hour
  localparam logic [3:0] MON_MAR = 4'h3;
  localparam logic [3:0] MON_NOV = 4'hB;
  localparam logic [4:0] DST_HOUR = 5'h02;

  typedef enum logic [2:0] {
    FMT_SMPTE30, FMT_SMPTE25, FMT_SMPTE24, FMT_IRIGB, FMT_RSVD
  } tcc_fmt_e;

  typedef enum logic [1:0] {
    ROUTE_SMPTE, ROUTE_IRIG_AM, ROUTE_IRIG_PWC, ROUTE_RSVD
  } tcc_route_e;

  typedef struct packed {
    logic [3:0] mag;
    logic neg;
    logic half;
    logic dst_en;
    tcc_fmt_e fmt;
    logic serial_special;
  } tcc_cfg_s;

  typedef struct packed {
    logic [8:0] doy;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [3:0] month;
    logic [4:0] mday;
    logic [2:0] wday;
    logic leap;
  } tcc_time_s;

endpackage : tcc_pkg

/* rtl/tcc_uart_tx.sv */
// Serial transmitter, 8N1, with back-to-back character loading.
// Assumes load is only pulsed while ready is high.
`timescale 1ns/1ps
`default_nettype none
module tcc_uart_tx import tcc_pkg::*; #(
  parameter int DIV = BAUD_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic load,
  input wire logic [7:0] data,
  output logic ready,
  output logic txd
);

  logic [9:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [31:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic last;

  // Ready also in the last stop-bit cycle so frames need no idle gap
  assign last = busy_q && bit_q == 4'(UART_BITS - 1) && cnt_q == 32'(DIV - 1);
  assign ready = !busy_q || last;
  assign txd = sh_q[0];

  // Shift sequence
  always_comb
  begin
    sh_d = sh_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (load && ready)
    begin
      sh_d = {1'b1, data, 1'b0};
      bit_d = 4'h0;
      cnt_d = 32'h0;
      busy_d = 1'b1;
    end
    else if (last)
    begin
      busy_d = 1'b0;
      sh_d = 10'h3FF;
    end
    else if (busy_q)
    begin
      if (cnt_q == 32'(DIV - 1))
      begin
        cnt_d = 32'h0;
        bit_d = bit_q + 4'h1;
        sh_d = {1'b1, sh_q[9:1]};
      end
      else
        cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_q <= 10'h3FF;
      bit_q <= 4'h0;
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
    end
    else if (ce)
    begin
      sh_q <= sh_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule : tcc_uart_tx
`default_nettype wire

/* rtl/tcc_dst.sv */
// Daylight period test for the North American rule from 2007.
// Assumes wday 0 is Sunday and hour is local standard time.
`timescale 1ns/1ps
`default_nettype none
module tcc_dst import tcc_pkg::*; (
  input wire logic [3:0] month,
  input wire logic [4:0] mday,
  input wire logic [2:0] wday,
  input wire logic [4:0] hour,
  output logic in_dst
);

  logic signed [6:0] prev_sun;
  logic sunday;

  // Date of the latest Sunday on or before today
  always_comb
  begin
    prev_sun = $signed({2'b00, mday}) - $signed({4'h0, wday});
    sunday = wday == 3'h0;
    in_dst = 1'b0;
    if (month > MON_MAR && month < MON_NOV)
      in_dst = 1'b1;
    else if (month == MON_MAR)
      in_dst = prev_sun >= 7'sd8 &&
        !(sunday && mday <= 5'd14 && hour < DST_HOUR);
    else if (month == MON_NOV)
      in_dst = prev_sun < 7'sd1 ||
        (sunday && mday <= 5'd7 && hour < DST_HOUR);
  end

endmodule : tcc_dst
`default_nettype wire

/* rtl/tcc_top.sv */
// Configuration, local time, serial broadcast and status outputs of a
// satellite-referenced time code generator.
// Assumes sec_tick pulses one cycle at each second and utc holds the time
// of the coming tick; waveforms arrive already synthesised.
`timescale 1ns/1ps
`default_nettype none
module tcc_top import tcc_pkg::*; #(
  parameter int CYC_PER_SEC = SEC_CYC,
  parameter int PPS_CYC = PPS_WIDTH_CYC,
  parameter int LED_ON_CYC = LED_FLASH_CYC,
  parameter int LED_HALF = LED_HALF_CYC,
  parameter int DIV = BAUD_DIV,
  parameter int LOSS_SECS = FIX_LOSS_SEC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [SW_WIDTH-1:0] config_switch_bank,
  input wire tcc_route_e output_route_select,
  input wire logic relay_polarity_jumper,
  input wire tcc_time_s utc,
  input wire logic sec_tick,
  input wire logic time_locked,
  input wire logic gps_fix3d,
  input wire logic gps_pps,
  input wire logic alarm_in,
  input wire logic native_txd,
  input wire logic tc_smpte,
  input wire logic tc_irig_am,
  input wire logic tc_irig_pwc,
  output tcc_cfg_s cfg,
  output tcc_time_s local_time,
  output logic dst_active,
  output logic serial_txd,
  output logic tc_unbal,
  output logic tc_bal,
  output logic pps_n,
  output logic relay_coil,
  output logic status_led
);

  localparam int FRAME = UART_BITS * DIV;
  // One cycle for the sequencer to load, so the CR load lands on the tick
  localparam int START_PH = CYC_PER_SEC - 2 - CR_IDX * FRAME;

  // Minute-of-day fold with day step: +1, -1 or none
  function automatic logic [14:0] fold(input logic [12:0] t);
    if (t[12])
      fold = {2'b11, t + MIN_PER_DAY};
    else if (t >= MIN_PER_DAY)
      fold = {2'b01, t - MIN_PER_DAY};
    else
      fold = {2'b00, t};
  endfunction : fold

  function automatic logic [7:0] asc(input int unsigned v);
    asc = CH_ZERO + 8'(v % 10);
  endfunction : asc

  // Switch capture group
  tcc_cfg_s cfg_q, cfg_d;
  logic cfg_valid_q, cfg_valid_d;
  tcc_fmt_e fmt_dec;

  always_comb
  begin
    case (config_switch_bank[SW_FMT_LSB +: 3])
      3'h0: fmt_dec = FMT_SMPTE30;
      3'h1: fmt_dec = FMT_SMPTE25;
      3'h2: fmt_dec = FMT_SMPTE24;
      3'h3: fmt_dec = FMT_IRIGB;
      default: fmt_dec = FMT_RSVD;
    endcase
    cfg_d = cfg_q;
    cfg_valid_d = 1'b1;
    if (!cfg_valid_q)
    begin
      cfg_d.mag = config_switch_bank[SW_MAG_LSB +: 4];
      cfg_d.neg = config_switch_bank[SW_NEG];
      cfg_d.half = config_switch_bank[SW_HALF];
      cfg_d.dst_en = config_switch_bank[SW_DST];
      cfg_d.fmt = fmt_dec;
      cfg_d.serial_special = config_switch_bank[SW_SERIAL];
    end
  end

  // Captured once after release; reset stands in for a power cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q <= '0;
      cfg_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      cfg_q <= cfg_d;
      cfg_valid_q <= cfg_valid_d;
    end
  end
  assign cfg = cfg_q;

  // Local time: magnitudes above 12 pass through unchecked
  logic [12:0] base_min, off_min, std_raw, dst_raw;
  logic [14:0] std_f, loc_f;
  logic [8:0] year_len;
  logic in_dst;
  tcc_time_s loc_d, loc_q;

  tcc_dst u_dst (
    .month(utc.month),
    .mday(utc.mday),
    .wday(utc.wday),
    .hour(5'(std_f[12:0] / MIN_PER_HOUR)),
    .in_dst(in_dst)
  );

  always_comb
  begin
    base_min = 13'(utc.hour) * MIN_PER_HOUR + 13'(utc.min);
    off_min = 13'(cfg_q.mag) * MIN_PER_HOUR
      + (cfg_q.half ? MIN_HALF_HOUR : 13'h0);
    std_raw = cfg_q.neg ? base_min - off_min
      : base_min + off_min;
    std_f = fold(std_raw);
    dst_raw = (cfg_q.dst_en && in_dst) ? std_raw + MIN_PER_HOUR
      : std_raw;
    loc_f = fold(dst_raw);
    year_len = DAYS_PER_YEAR + 9'(utc.leap);
    loc_d = utc;
    loc_d.hour = 5'(loc_f[12:0] / MIN_PER_HOUR);
    loc_d.min = 6'(loc_f[12:0] % MIN_PER_HOUR);
    if (loc_f[14:13] == 2'b01)
      loc_d.doy = (utc.doy >= year_len) ? 9'h001 : utc.doy + 9'h001;
    else if (loc_f[14:13] == 2'b11)
      loc_d.doy = (utc.doy <= 9'h001) ? year_len : utc.doy - 9'h001;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      loc_q <= '0;
      dst_active <= 1'b0;
    end
    else if (ce)
    begin
      loc_q <= loc_d;
      dst_active <= cfg_q.dst_en && in_dst;
    end
  end
  assign local_time = loc_q;

  // Second phase counter restarted by each tick
  logic [31:0] ph_q, ph_d;
  logic ever_lock_q, ever_lock_d;
  always_comb
  begin
    ph_d = ph_q;
    if (sec_tick)
      ph_d = 32'h0;
    else if (ph_q != 32'(CYC_PER_SEC - 1))
      ph_d = ph_q + 32'h1;
    ever_lock_d = ever_lock_q || time_locked;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_q <= 32'h0;
      ever_lock_q <= 1'b0;
    end
    else if (ce)
    begin
      ph_q <= ph_d;
      ever_lock_q <= ever_lock_d;
    end
  end

  // Broadcast sequencer; string snapshot held in flops
  typedef enum logic {SER_IDLE, SER_SEND} tcc_ser_e;
  tcc_ser_e ser_q, ser_d;
  logic [7:0] str_q [STR_LEN], str_d [STR_LEN];
  logic [3:0] idx_q, idx_d;
  logic bcast, ld, u_ready, u_txd;
  assign bcast = cfg_q.serial_special && cfg_q.fmt == FMT_IRIGB;

  always_comb
  begin
    ser_d = ser_q;
    idx_d = idx_q;
    str_d = str_q;
    ld = 1'b0;
    case (ser_q)
      SER_IDLE:
        if (bcast && ph_q == 32'(START_PH))
        begin
          str_d[0] = CH_SOH;
          str_d[1] = asc(loc_d.doy / 100);
          str_d[2] = asc(loc_d.doy / 10);
          str_d[3] = asc(loc_d.doy);
          str_d[4] = CH_COLON;
          str_d[5] = asc(loc_d.hour / 10);
          str_d[6] = asc(loc_d.hour);
          str_d[7] = CH_COLON;
          str_d[8] = asc(loc_d.min / 10);
          str_d[9] = asc(loc_d.min);
          str_d[10] = CH_COLON;
          str_d[11] = asc(loc_d.sec / 10);
          str_d[12] = asc(loc_d.sec);
          str_d[13] = time_locked ? CH_LOCKED : CH_UNLOCKED;
          str_d[14] = CH_CR;
          str_d[15] = CH_LF;
          idx_d = 4'h0;
          ser_d = SER_SEND;
        end
      SER_SEND:
        if (u_ready)
        begin
          ld = 1'b1; // Frames chained so CR timing stays exact
          idx_d = idx_q + 4'h1;
          if (idx_q == 4'(STR_LEN - 1))
            ser_d = SER_IDLE;
        end
      default: ser_d = SER_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ser_q <= SER_IDLE;
      idx_q <= 4'h0;
      for (int i = 0; i < STR_LEN; i++)
        str_q[i] <= 8'h00;
    end
    else if (ce)
    begin
      ser_q <= ser_d;
      idx_q <= idx_d;
      str_q <= str_d;
    end
  end

  tcc_uart_tx #(.DIV(DIV)) u_tx (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .load(ld),
    .data(str_q[idx_q]),
    .ready(u_ready),
    .txd(u_txd)
  );

  // Pulse per second with fix supervision
  logic pps_en_q, pps_en_d;
  logic [31:0] loss_q, loss_d, pw_q, pw_d;
  always_comb
  begin
    pps_en_d = pps_en_q;
    loss_d = loss_q;
    pw_d = pw_q;
    if (gps_fix3d)
    begin
      pps_en_d = 1'b1;
      loss_d = 32'h0;
    end
    else if (sec_tick && pps_en_q)
    begin
      loss_d = loss_q + 32'h1;
      if (loss_q == 32'(LOSS_SECS - 1))
        pps_en_d = 1'b0;
    end
    if (gps_pps && pps_en_q)
      pw_d = 32'(PPS_CYC);
    else if (pw_q != 32'h0)
      pw_d = pw_q - 32'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pps_en_q <= 1'b0;
      loss_q <= 32'h0;
      pw_q <= 32'h0;
    end
    else if (ce)
    begin
      pps_en_q <= pps_en_d;
      loss_q <= loss_d;
      pw_q <= pw_d;
    end
  end
  assign pps_n = pw_q == 32'h0;

  // Output flops: serial mux, routing, relay and LED
  logic ser_nx, unb_nx, bal_nx, led_nx;
  always_comb
  begin
    if (!cfg_q.serial_special)
      ser_nx = native_txd;
    else if (bcast)
      ser_nx = u_txd;
    else
      ser_nx = 1'b1;
    case (output_route_select)
      ROUTE_SMPTE: unb_nx = tc_smpte;
      ROUTE_IRIG_AM: unb_nx = tc_irig_am;
      ROUTE_IRIG_PWC: unb_nx = tc_irig_pwc;
      default: unb_nx = 1'b0;
    endcase
    // Balanced never carries the modulated waveform
    case (output_route_select)
      ROUTE_SMPTE: bal_nx = tc_smpte;
      ROUTE_IRIG_PWC: bal_nx = tc_irig_pwc;
      ROUTE_IRIG_AM: bal_nx = tc_irig_pwc;
      default: bal_nx = 1'b0;
    endcase
    if (!ever_lock_q)
      led_nx = 1'b1;
    else if (time_locked)
      led_nx = ph_q < 32'(LED_HALF);
    else
      led_nx = ph_q < 32'(LED_ON_CYC) || (ph_q >= 32'(LED_HALF) &&
        ph_q < 32'(LED_HALF + LED_ON_CYC));
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_txd <= 1'b1;
      tc_unbal <= 1'b0;
      tc_bal <= 1'b0;
      relay_coil <= 1'b0;
      status_led <= 1'b0;
    end
    else if (ce)
    begin
      serial_txd <= ser_nx;
      tc_unbal <= unb_nx;
      tc_bal <= bal_nx;
      relay_coil <= (time_locked && !alarm_in) ^ relay_polarity_jumper;
      status_led <= led_nx;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_CFG_FROZEN: assert property ($past(cfg_valid_q) |-> $stable(cfg_q))
    else $error("configuration changed after capture");
  AST_NATIVE: assert property (ce && !cfg_q.serial_special |=>
    serial_txd == $past(native_txd))
    else $error("native serial not passed");
  AST_SOH: assert property (ld && idx_q == 4'h0 |-> str_q[0] == CH_SOH)
    else $error("string does not open with SOH");
  AST_QUAL: assert property (ce && ser_q == SER_IDLE && ser_d == SER_SEND |=>
    str_q[13] == ($past(time_locked) ? CH_LOCKED : CH_UNLOCKED))
    else $error("quality character wrong");
  AST_CR_TIME: assert property (ce && ld && idx_q == 4'(CR_IDX) |->
    ph_q == 32'(CYC_PER_SEC - 1))
    else $error("CR start bit off the second");
  AST_RSVD_IDLE: assert property (cfg_q.serial_special && !bcast |=> serial_txd)
    else $error("line not idle in reserved mode");
  AST_PPS_FALL: assert property ($fell(pps_n) |-> $past(gps_pps && pps_en_q))
    else $error("pulse fell without a receiver edge");
  AST_PPS_SUPP: assert property (!pps_en_q && pw_q == 32'h0 |-> pps_n)
    else $error("pulse while suppressed");
  AST_BAL_AM: assert property (ce && output_route_select == ROUTE_IRIG_AM |=>
    tc_bal == $past(tc_irig_pwc) && tc_unbal == $past(tc_irig_am))
    else $error("balanced output wrong in modulated route");
  AST_RELAY: assert property (ce && alarm_in |=>
    relay_coil == $past(relay_polarity_jumper))
    else $error("relay not in alarm state");
  AST_LED: assert property (ce && sec_tick && time_locked && ever_lock_q |=>
    ce [*1] ##1 status_led)
    else $error("LED not on at the second");

  COV_BCAST: cover property (ld && idx_q == 4'(CR_IDX));
  COV_PPS: cover property ($rose(pps_n));
  COV_FREE: cover property (ever_lock_q && !time_locked && status_led);

endmodule : tcc_top
`default_nettype wire

/* tb/tcc_serial_host.sv */
// Serial host model: receives 8N1 characters from the block's TX line.
// Assumes the line idles high and a bit lasts DIV clock cycles.
`timescale 1ns/1ps
`default_nettype none
module tcc_serial_host #(
  parameter int DIV = 8
) (
  input wire logic clk,
  input wire logic rxd,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic [63:0] start_t
);
  logic [7:0] sh;
  // Bits are sampled mid-cell, so a one-cycle skew still decodes
  initial
  begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    start_t = 64'h0;
    sh = 8'h00;
    forever
    begin
      @(posedge clk);
      rx_valid <= 1'b0;
      if (rxd === 1'b0)
      begin
        start_t <= $time;
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (DIV) @(posedge clk);
          sh[i] = rxd;
        end
        repeat (DIV) @(posedge clk);
        rx_byte <= sh;
        rx_valid <= 1'b1;
      end
    end
  end
endmodule : tcc_serial_host
`default_nettype wire

/* tb/timecode_config_and_status_test.sv */
// Self-checking bench for the time code configuration and status block.
// Assumes shortened second (4000 cycles) and an 8-cycle serial bit.
`timescale 1ns/1ps
`default_nettype none
module timecode_config_and_status_test;
  import tcc_pkg::*;
  localparam int SEC = 4000;
  localparam int PPSC = 400;
  logic clk, rstn, sec_tick, time_locked, gps_fix3d, gps_pps, alarm_in;
  logic relay_polarity_jumper, native_txd, tc_smpte, tc_irig_am, tc_irig_pwc;
  logic dst_active, serial_txd, tc_unbal, tc_bal, pps_n, relay_coil, led;
  logic rx_valid, eu, eb, ce;
  logic [11:0] sw;
  logic [7:0] rx_byte;
  logic [63:0] start_t, cr_t, tick_t;
  tcc_route_e route;
  tcc_time_s utc, u0, local_time;
  tcc_cfg_s cfg, ec;
  int miscompares, total_checks, cyc, seed, m, n, first;
  byte unsigned rxq[$];
  logic [11:0] cfgs[5] = '{12'h035, 12'h10C, 12'h226, 12'h300, 12'h700};
  int dtab[6][5] = '{'{3, 8, 0, 1, 0}, '{3, 8, 0, 3, 1}, '{3, 1, 0, 3, 0},
    '{7, 10, 3, 10, 1}, '{10, 31, 6, 12, 1}, '{11, 1, 0, 12, 0}};

  tcc_top #(.CYC_PER_SEC(SEC), .PPS_CYC(PPSC), .LED_ON_CYC(500),
    .LED_HALF(2000), .DIV(8), .LOSS_SECS(3)) tcc_top_i (
    .clk(clk), .rstn(rstn), .ce(ce), .config_switch_bank(sw),
    .output_route_select(route),
    .relay_polarity_jumper(relay_polarity_jumper), .utc(utc),
    .sec_tick(sec_tick), .time_locked(time_locked), .gps_fix3d(gps_fix3d),
    .gps_pps(gps_pps), .alarm_in(alarm_in), .native_txd(native_txd),
    .tc_smpte(tc_smpte), .tc_irig_am(tc_irig_am),
    .tc_irig_pwc(tc_irig_pwc), .cfg(cfg), .local_time(local_time),
    .dst_active(dst_active), .serial_txd(serial_txd), .tc_unbal(tc_unbal),
    .tc_bal(tc_bal), .pps_n(pps_n), .relay_coil(relay_coil),
    .status_led(led));

  tcc_serial_host #(.DIV(8)) tcc_serial_host_i (.clk(clk),
    .rxd(serial_txd), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .start_t(start_t));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Collect host characters; keep the CR start-bit time
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
    begin
      rxq.push_back(rx_byte);
      if (rx_byte === 8'h0D)
        cr_t = start_t;
    end
  end

  // Hang guard: the whole run needs about 17150 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      miscompares++;
      stop_test;
    end
  end

  task automatic tk;
    @(posedge clk);
    #1;
  endtask : tk

  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Reset stands in for a power cycle; switches are set beforehand
  task automatic do_reset(input logic [11:0] s);
    rstn = 1'b0;
    sw = s;
    repeat (20) tk;
    rstn = 1'b1;
    repeat (3) tk;
  endtask : do_reset

  function automatic tcc_cfg_s exp_cfg(input logic [11:0] s);
    tcc_cfg_s c;
    c = '{mag: s[3:0], neg: s[4], half: s[5], dst_en: s[6],
      fmt: FMT_RSVD, serial_special: s[11]};
    if (s[10:8] == 3'h0) c.fmt = FMT_SMPTE30;
    if (s[10:8] == 3'h1) c.fmt = FMT_SMPTE25;
    if (s[10:8] == 3'h2) c.fmt = FMT_SMPTE24;
    if (s[10:8] == 3'h3) c.fmt = FMT_IRIGB;
    return c;
  endfunction : exp_cfg

  function automatic byte unsigned dg(input int v);
    return 8'(8'h30 + v);
  endfunction : dg

  // One second of ticks; lock level lk applies to the next string
  task automatic one_sec(input logic do_chk, input logic lk);
    byte unsigned ex[$];
    ex = '{8'h01, dg(utc.doy / 100), dg(utc.doy / 10 % 10), dg(utc.doy % 10),
      8'h3A, dg(utc.hour / 10), dg(utc.hour % 10), 8'h3A, dg(utc.min / 10),
      dg(utc.min % 10), 8'h3A, dg(utc.sec / 10), dg(utc.sec % 10),
      time_locked ? 8'h20 : 8'h3F, 8'h0D, 8'h0A};
    sec_tick = 1'b1;
    tick_t = $time + 4;
    tk;
    sec_tick = 1'b0;
    utc.sec = utc.sec + 6'h01;
    repeat (200) tk;
    if (do_chk)
    begin
      chk(rxq == ex, "broadcast string");
      chk(cr_t - tick_t <= 10 && cr_t >= tick_t + 5, "on-time mark");
    end
    rxq.delete();
    time_locked = lk;
    // A quarter second in, the locked blink is on and the freewheel flash is off
    repeat (800) tk;
    chk(led === lk, "status indicator");
    repeat (SEC - 1001) tk;
  endtask : one_sec

  task automatic pps_count;
    gps_pps = 1'b1;
    tk;
    gps_pps = 1'b0;
    n = 0;
    first = -1;
    for (int j = 0; j < PPSC + 20; j++)
    begin
      if (pps_n === 1'b0 && first < 0) first = j;
      if (pps_n === 1'b0) n++;
      tk;
    end
  endtask : pps_count

  initial
  begin
    seed = 32'h68822853;
    {rstn, sec_tick, gps_fix3d, gps_pps, alarm_in} = 5'h00;
    {relay_polarity_jumper, tc_smpte, tc_irig_am, tc_irig_pwc} = 4'h0;
    {ce, time_locked, native_txd} = 3'h7;
    route = ROUTE_SMPTE;
    sw = 12'h000;
    u0 = '{doy: 9'h02D, hour: 5'h0A, min: 6'h07, sec: 6'h05, month: 4'h1,
      mday: 5'h0F, wday: 3'h4, leap: 1'b0};
    utc = u0;
    // Capture once, signed offset, format, then switch changes ignored
    foreach (cfgs[k])
    begin
      do_reset(cfgs[k]);
      ec = exp_cfg(cfgs[k]);
      chk(cfg === ec, "capture");
      m = (cfgs[k][3:0] * 60 + (cfgs[k][5] ? 30 : 0)) * (cfgs[k][4] ? -1 : 1);
      m = m + 607;
      chk(local_time.hour === 5'(m / 60), "hour");
      chk(local_time.min === 6'(m % 60), "minute");
      sw = 12'($random(seed));
      repeat (4) tk;
      chk(cfg === ec, "held");
    end
    $display("test capture done");
    // Daylight window edges around the March and November Sundays
    do_reset(12'h040);
    foreach (dtab[i])
    begin
      utc.month = 4'(dtab[i][0]);
      utc.mday = 5'(dtab[i][1]);
      utc.wday = 3'(dtab[i][2]);
      utc.hour = 5'(dtab[i][3]);
      repeat (2) tk;
      chk(dst_active === 1'(dtab[i][4]), "dst window");
      chk(local_time.hour === 5'(dtab[i][3] + dtab[i][4]), "dst hour");
    end
    utc = u0;
    $display("test daylight done");
    // IRIG-B with position 12 off: native line, routing and relay
    do_reset(12'h300);
    for (int i = 0; i < 64; i++)
    begin
      {native_txd, tc_smpte, tc_irig_am, tc_irig_pwc} = 4'($random(seed));
      {relay_polarity_jumper, time_locked, alarm_in} = 3'($random(seed));
      route = tcc_route_e'(2'($random(seed)));
      eu = route == ROUTE_SMPTE ? tc_smpte :
        (route == ROUTE_IRIG_AM ? tc_irig_am : tc_irig_pwc);
      eb = route == ROUTE_SMPTE ? tc_smpte : tc_irig_pwc;
      tk;
      chk(serial_txd === native_txd, "native");
      chk(relay_coil === ((time_locked & ~alarm_in) ^ relay_polarity_jumper),
        "relay");
      if (route != ROUTE_RSVD)
      begin
        chk(tc_unbal === eu, "unbalanced");
        chk(tc_bal === eb, "balanced");
      end
      else
        chk(tc_unbal === 1'b0 && tc_bal === 1'b0, "reserved route");
    end
    // Clock enable low freezes the output flops
    ce = 1'b0;
    eu = serial_txd;
    native_txd = ~serial_txd;
    repeat (3) tk;
    chk(serial_txd === eu, "frozen by enable");
    ce = 1'b1;
    tk;
    chk(serial_txd === native_txd, "resumed after enable");
    $display("test routing done");
    // Reserved serial mode idles; pulse held off until a fix
    do_reset(12'h800);
    native_txd = 1'b0;
    time_locked = 1'b1;
    repeat (2) tk;
    chk(serial_txd === 1'b1, "reserved idle");
    pps_count;
    chk(n == 0, "pulse before fix");
    gps_fix3d = 1'b1;
    tk;
    pps_count;
    chk(n == PPSC, "pulse width");
    chk(first >= 0 && first <= 1, "pulse edge");
    $display("test pulse done");
    // Broadcast: locked string, unlocked string, locked again
    do_reset(12'hB00);
    one_sec(1'b0, 1'b1);
    one_sec(1'b1, 1'b0);
    one_sec(1'b1, 1'b1);
    one_sec(1'b1, 1'b1);
    $display("test broadcast done");
    stop_test;
  end
endmodule : timecode_config_and_status_test
`default_nettype wire
